/* core/tmr_pkg.sv */
package tmr_pkg;
   localparam int NUM_TIMERS = 3;
   localparam int ADDR_MIN = 12;
   localparam int SEL_LSB = 10;
   localparam int IDX_LSB = 2;
   localparam logic [7:0] IDX_TIMER_CONTROL_REG = 8'hC8;
   localparam logic [7:0] IDX_TIMER_CONFIG_REG = 8'hC9;
   localparam logic [7:0] IDX_RELOAD_CAPTURE_LOW = 8'hCA;
   localparam logic [7:0] IDX_RELOAD_CAPTURE_HIGH = 8'hCB;
   localparam logic [7:0] IDX_COUNT_LOW_REG = 8'hCC;
   localparam logic [7:0] IDX_COUNT_HIGH_REG = 8'hCD;
   localparam int CTL_WRAP = 7;
   localparam int CTL_EXT = 6;
   localparam int CTL_EXEN = 3;
   localparam int CTL_RUN = 2;
   localparam int CTL_SRC = 1;
   localparam int CTL_CPRL = 0;
   localparam int CFG_CLK_HI = 4;
   localparam int CFG_CLK_LO = 3;
   localparam int CFG_TOG = 2;
   localparam int CFG_TOE = 1;
   localparam int CFG_DCEN = 0;
   localparam logic [1:0] CLK_DIV12 = 2'h0;
   localparam logic [1:0] CLK_SYS = 2'h1;
   localparam logic [1:0] CLK_EXT8 = 2'h2;
   localparam logic [1:0] CLK_DIV2 = 2'h3;
   localparam logic [3:0] DIV12_LAST = 4'hB;
   localparam logic [2:0] DIV8_LAST = 3'h7;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   localparam logic [15:0] COUNT_TOP = 16'hFFFF;
   localparam logic [2:0] TOGGLE_TIMERS = 3'h5;
   localparam int PIN_SH_CNT = 0;
   localparam int PIN_CNT4 = 1;
   localparam int PIN_SH_EV = 2;
   localparam int PIN_EV4 = 3;
   localparam int PIN_OSC = 4;
   localparam int NUM_PINS = 5;

   typedef struct packed {
      logic [15:0] count;
      logic [15:0] reload;
      logic wrap_flag;
      logic ext_event_flag;
      logic ext_trigger_enable;
      logic run_control;
      logic count_source_select;
      logic capture_reload_select;
      logic [1:0] clk_select;
      logic toggle_state_bit;
      logic toggle_out_enable;
      logic down_count_enable;
   } timer_t;

   typedef struct packed {
      logic [NUM_PINS-1:0] s1;
      logic [NUM_PINS-1:0] s2;
      logic [NUM_PINS-1:0] s3;
      logic [NUM_PINS-1:0] filt;
   } sync_t;

   typedef struct packed {
      timer_t [NUM_TIMERS-1:0] tmr;
      sync_t sync;
      logic div2;
      logic [3:0] div12;
      logic [2:0] div8;
      logic [NUM_TIMERS-1:0] wrap_pulse;
      logic [NUM_TIMERS-1:0] irq_req;
      logic [1:0] pin_oe;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } state_t;
endpackage

/* core/updown_timer_capture_reload.sv */
// Functional notes
// - Each timer keeps a 16-bit count as software-accessible low and high bytes.
// - Source bit 0 counts internal clock ticks; 1 counts count pin falling edges.
// - Timer clock is system_clock_source, system_clock_source/2, system_clock_source/12 or external oscillator/8.
// - Second timer shares count and event pins with the first timer; the third has its own.
// - With down-count enable, event pin high counts up, low counts down.
// - With down-count enable, event pin edges cause no capture or reload.
// - Capture mode with trigger enable: event pin fall copies count to capture pair.
// - Each capture sets the external event flag, bit 6, and requests interrupt.
// - Capture mode up-count overflow sets the wrap flag, bit 7, and requests interrupt.
// - Capture mode down-count decrements; 0x0000 to 0xFFFF sets the wrap flag.
// - Bit 0 set selects capture mode; timer counts only while run bit 2 is set.
// - Trigger enable bit 3 clear makes event pin edges ignored.
// - Reload mode up-count overflow sets wrap flag, loads reload pair, keeps counting.
// - Reload mode, trigger on, down-count off: event pin fall forces reload.
// - Reload mode with down-count enable: event pin only sets direction.
// - Reload mode down-count: count equal to reload pair wraps to 0xFFFF.
// - Bit 0 clear selects reload mode; run bit starts counting.
// - Reload mode: external event flag inverts on every wrap; it requests interrupt only with trigger on and down-count off.
// - First and third timers toggle their output on reload-mode wraps from the internal clock when enabled.
// - Toggle state bit reads the output level; writing forces the level.
// - Square wave frequency is timer clock over 2*(65536 - reload).
// - Wraps of timers one and two start ADC; all three update DAC.
// - Clock field: 00 system_clock_source/12, 01 system_clock_source, 10 external/8, 11 system_clock_source/2.
module updown_timer_capture_reload #(
   parameter int ADDR_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic shared_count_pin_i,
   output logic shared_count_pin_o,
   output logic shared_count_pin_oe,
   input wire logic count_input_pin_i,
   output logic count_input_pin_o,
   output logic count_input_pin_oe,
   input wire logic shared_event_pin,
   input wire logic ext_event_pin,
   input wire logic oscillator_pins,
   output logic [2:0] irq_req,
   output logic [1:0] adc_start,
   output logic [2:0] dac_update
);
   if (ADDR_W < tmr_pkg::ADDR_MIN) begin : g_bad_addr
      $error("ADDR_W too small for the timer register map");
   end

   tmr_pkg::state_t q;
   tmr_pkg::state_t n;
   logic [tmr_pkg::NUM_PINS-1:0] pins;
   logic [tmr_pkg::NUM_PINS-1:0] pin_fall;
   logic osc_rise;
   logic tick2;
   logic tick12;
   logic tick_ext;
   logic [2:0] ev_fall;
   logic [2:0] ev_lvl;
   logic [2:0] step;
   logic [2:0] up;
   logic [2:0] trig;
   logic [2:0] wrap;
   logic [2:0] wr_any;
   logic hit;
   logic [1:0] sel;
   logic [7:0] idx;
   logic wr_go;
   logic rd_go;
   logic [31:0] rd_val;

   assign pins = {oscillator_pins, ext_event_pin, shared_event_pin,
                  count_input_pin_i, shared_count_pin_i};

   always_comb begin
      tmr_pkg::timer_t t;
      logic clk_tick;
      logic cnt_f;
      logic exf_w;
      t = '0;
      clk_tick = 1'b0;
      cnt_f = 1'b0;
      exf_w = 1'b0;
      n = q;
      // Three stages; the filtered level moves only when stages two and
      // three agree, so a single glitchy sample never makes an edge.
      n.sync.s1 = pins;
      n.sync.s2 = q.sync.s1;
      n.sync.s3 = q.sync.s2;
      for (int p = 0; p < tmr_pkg::NUM_PINS; p++) begin
         if (q.sync.s2[p] == q.sync.s3[p]) begin
            n.sync.filt[p] = q.sync.s3[p];
         end
      end
      pin_fall = q.sync.filt & ~n.sync.filt;
      osc_rise = ~q.sync.filt[tmr_pkg::PIN_OSC] & n.sync.filt[tmr_pkg::PIN_OSC];
      // Prescalers are shared by all timers
      n.div2 = ~q.div2;
      if (q.div12 == tmr_pkg::DIV12_LAST) begin
         n.div12 = 4'h0;
      end else begin
         n.div12 = q.div12 + 4'h1;
      end
      if (osc_rise) begin
         n.div8 = q.div8 + 3'h1;
      end
      tick2 = q.div2;
      tick12 = (q.div12 == tmr_pkg::DIV12_LAST);
      tick_ext = osc_rise && (q.div8 == tmr_pkg::DIV8_LAST);

      // APB decode: word index in the low field, timer in the upper field
      sel = paddr[tmr_pkg::SEL_LSB +: 2];
      idx = paddr[tmr_pkg::IDX_LSB +: 8];
      hit = (paddr[1:0] == 2'h0) && (sel < 2'h3) &&
            (idx >= tmr_pkg::IDX_TIMER_CONTROL_REG) &&
            (idx <= tmr_pkg::IDX_COUNT_HIGH_REG);
      // Two-cycle access: pready rises one cycle into the access phase
      wr_go = psel && penable && pwrite && q.pready && hit;
      rd_go = psel && penable && !pwrite && !q.pready;
      n.pready = psel && penable && !q.pready;
      n.pslverr = psel && penable && !q.pready && !hit;
      rd_val = 32'h0000_0000;
      t = q.tmr[sel];
      if (!hit) begin
         rd_val = 32'h0000_0000;
      end else if (idx == tmr_pkg::IDX_TIMER_CONTROL_REG) begin
         rd_val[7:0] = {t.wrap_flag, t.ext_event_flag, 2'h0,
                        t.ext_trigger_enable, t.run_control,
                        t.count_source_select, t.capture_reload_select};
      end else if (idx == tmr_pkg::IDX_TIMER_CONFIG_REG) begin
         rd_val[7:0] = {3'h0, t.clk_select,
                        t.toggle_state_bit && tmr_pkg::TOGGLE_TIMERS[sel],
                        t.toggle_out_enable, t.down_count_enable};
      end else if (idx == tmr_pkg::IDX_RELOAD_CAPTURE_LOW) begin
         rd_val[7:0] = t.reload[7:0];
      end else if (idx == tmr_pkg::IDX_RELOAD_CAPTURE_HIGH) begin
         rd_val[7:0] = t.reload[15:8];
      end else if (idx == tmr_pkg::IDX_COUNT_LOW_REG) begin
         rd_val[7:0] = t.count[7:0];
      end else begin
         rd_val[7:0] = t.count[15:8];
      end
      if (rd_go) begin
         n.prdata = rd_val;
      end

      for (int i = 0; i < tmr_pkg::NUM_TIMERS; i++) begin
         t = q.tmr[i];
         // Third timer has its own count and event pins; the first two timers share theirs
         if (i == 2) begin
            ev_lvl[i] = q.sync.filt[tmr_pkg::PIN_EV4];
            ev_fall[i] = pin_fall[tmr_pkg::PIN_EV4];
            cnt_f = pin_fall[tmr_pkg::PIN_CNT4];
         end else begin
            ev_lvl[i] = q.sync.filt[tmr_pkg::PIN_SH_EV];
            ev_fall[i] = pin_fall[tmr_pkg::PIN_SH_EV];
            cnt_f = pin_fall[tmr_pkg::PIN_SH_CNT];
         end
         case (t.clk_select)
            tmr_pkg::CLK_DIV12: clk_tick = tick12;
            tmr_pkg::CLK_SYS: clk_tick = 1'b1;
            tmr_pkg::CLK_EXT8: clk_tick = tick_ext;
            default: clk_tick = tick2;
         endcase
         step[i] = t.run_control &&
                   (t.count_source_select ? cnt_f : clk_tick);
         up[i] = !t.down_count_enable || ev_lvl[i];
         trig[i] = t.ext_trigger_enable && !t.down_count_enable &&
                   ev_fall[i];
         wrap[i] = 1'b0;
         if (t.capture_reload_select) begin
            if (step[i]) begin
               if (up[i]) begin
                  wrap[i] = (t.count == tmr_pkg::COUNT_TOP);
                  t.count = t.count + 16'h0001;
               end else begin
                  wrap[i] = (t.count == tmr_pkg::COUNT_ZERO);
                  t.count = t.count - 16'h0001;
               end
            end
            if (trig[i]) begin
               t.reload = q.tmr[i].count;
               t.ext_event_flag = 1'b1;
            end
         end else begin
            if (step[i]) begin
               if (up[i]) begin
                  if (t.count == tmr_pkg::COUNT_TOP) begin
                     wrap[i] = 1'b1;
                     t.count = t.reload;
                  end else begin
                     t.count = t.count + 16'h0001;
                  end
               end else if (t.count == t.reload) begin
                  wrap[i] = 1'b1;
                  t.count = tmr_pkg::COUNT_TOP;
               end else begin
                  t.count = t.count - 16'h0001;
               end
            end
            if (wrap[i]) begin
               t.ext_event_flag = !t.ext_event_flag;
            end
            if (trig[i]) begin
               t.count = t.reload;
               t.ext_event_flag = 1'b1;
            end
         end
         if (wrap[i]) begin
            t.wrap_flag = 1'b1;
         end
         // Square wave period is two wraps of (65536 - reload) ticks
         if (tmr_pkg::TOGGLE_TIMERS[i] && !t.capture_reload_select &&
             !t.count_source_select && t.toggle_out_enable && wrap[i]) begin
            t.toggle_state_bit = !t.toggle_state_bit;
         end

         // Software writes; hardware flag sets still win the same cycle
         wr_any[i] = wr_go && (sel == 2'(i));
         if (wr_any[i]) begin
            if (idx == tmr_pkg::IDX_TIMER_CONTROL_REG) begin
               exf_w = pwdata[tmr_pkg::CTL_EXT];
               if (!t.capture_reload_select && wrap[i]) begin
                  exf_w = !exf_w;
               end
               t.wrap_flag = pwdata[tmr_pkg::CTL_WRAP] || wrap[i];
               t.ext_event_flag = exf_w || trig[i];
               t.ext_trigger_enable = pwdata[tmr_pkg::CTL_EXEN];
               t.run_control = pwdata[tmr_pkg::CTL_RUN];
               t.count_source_select = pwdata[tmr_pkg::CTL_SRC];
               t.capture_reload_select = pwdata[tmr_pkg::CTL_CPRL];
            end else if (idx == tmr_pkg::IDX_TIMER_CONFIG_REG) begin
               t.clk_select = pwdata[tmr_pkg::CFG_CLK_LO +: 2];
               t.toggle_state_bit = pwdata[tmr_pkg::CFG_TOG];
               t.toggle_out_enable = pwdata[tmr_pkg::CFG_TOE];
               t.down_count_enable = pwdata[tmr_pkg::CFG_DCEN];
            end else if (idx == tmr_pkg::IDX_RELOAD_CAPTURE_LOW) begin
               if (!(q.tmr[i].capture_reload_select && trig[i])) begin
                  t.reload[7:0] = pwdata[7:0];
               end
            end else if (idx == tmr_pkg::IDX_RELOAD_CAPTURE_HIGH) begin
               if (!(q.tmr[i].capture_reload_select && trig[i])) begin
                  t.reload[15:8] = pwdata[7:0];
               end
            end else if (idx == tmr_pkg::IDX_COUNT_LOW_REG) begin
               t.count[7:0] = pwdata[7:0];
            end else begin
               t.count[15:8] = pwdata[7:0];
            end
         end
         n.tmr[i] = t;
         n.wrap_pulse[i] = wrap[i];
         // Event flag only asks for service when it marks a pin event
         n.irq_req[i] = t.wrap_flag ||
                        (t.ext_event_flag && (t.capture_reload_select ||
                         (t.ext_trigger_enable && !t.down_count_enable)));
      end
      n.pin_oe[0] = !n.tmr[0].capture_reload_select &&
                    !n.tmr[0].count_source_select && n.tmr[0].toggle_out_enable;
      n.pin_oe[1] = !n.tmr[2].capture_reload_select &&
                    !n.tmr[2].count_source_select && n.tmr[2].toggle_out_enable;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign shared_count_pin_o = q.tmr[0].toggle_state_bit;
   assign shared_count_pin_oe = q.pin_oe[0];
   assign count_input_pin_o = q.tmr[2].toggle_state_bit;
   assign count_input_pin_oe = q.pin_oe[1];
   assign irq_req = q.irq_req;
   assign adc_start = q.wrap_pulse[1:0];
   assign dac_update = q.wrap_pulse;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable;
   endsequence

   apb_ready_a: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
      else $error("pready not one cycle into access");

   up_wrap_a: assert property (
      !q.tmr[0].capture_reload_select && step[0] && up[0] && !trig[0] &&
      q.tmr[0].count == 16'hFFFF && !wr_any[0]
      |=> q.tmr[0].count == $past(q.tmr[0].reload) && q.tmr[0].wrap_flag)
      else $error("reload on overflow missing");

   down_match_a: assert property (
      !q.tmr[0].capture_reload_select && step[0] && !up[0] && !trig[0] &&
      q.tmr[0].count == q.tmr[0].reload && !wr_any[0]
      |=> q.tmr[0].count == 16'hFFFF && dac_update[0])
      else $error("underflow did not load all ones");

   cap_copy_a: assert property (
      q.tmr[1].capture_reload_select && trig[1]
      |=> q.tmr[1].reload == $past(q.tmr[1].count) &&
          q.tmr[1].ext_event_flag)
      else $error("capture did not copy count");

   cap_down_a: assert property (
      q.tmr[0].capture_reload_select && step[0] && !up[0] &&
      q.tmr[0].count == 16'h0000 && !wr_any[0]
      |=> q.tmr[0].count == 16'hFFFF && q.tmr[0].wrap_flag)
      else $error("capture down wrap wrong");

   dir_only_a: assert property (
      q.tmr[0].down_count_enable && ev_fall[0] |-> !trig[0])
      else $error("event edge acted with down count on");

   exf_toggle_a: assert property (
      !q.tmr[2].capture_reload_select && wrap[2] && !trig[2] && !wr_any[2]
      |=> q.tmr[2].ext_event_flag != $past(q.tmr[2].ext_event_flag))
      else $error("event flag did not invert on wrap");

   sq_toggle_a: assert property (
      q.pin_oe[0] && wrap[0] && !wr_any[0]
      |=> shared_count_pin_o != $past(shared_count_pin_o))
      else $error("toggle output missed a wrap");

   flag_hold_a: assert property (
      q.tmr[0].wrap_flag && !wr_any[0] |=> q.tmr[0].wrap_flag)
      else $error("wrap flag cleared without a write");

   halt_a: assert property (
      !q.tmr[1].run_control && !trig[1] && !wr_any[1]
      |=> $stable(q.tmr[1].count))
      else $error("stopped timer changed count");

   one_event_a: assert property (
      pin_fall[tmr_pkg::PIN_SH_EV] |=> !pin_fall[tmr_pkg::PIN_SH_EV])
      else $error("event pulse longer than one cycle");

   ext_off_a: assert property (
      !q.tmr[2].ext_trigger_enable |-> !trig[2])
      else $error("event edge used while trigger off");
endmodule

/* test/pin_model.sv */
module pin_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [3:0] lvl,
   input wire logic shared_count_pin_o,
   input wire logic shared_count_pin_oe,
   input wire logic count_input_pin_o,
   input wire logic count_input_pin_oe,
   output logic shared_count_pin_i,
   output logic count_input_pin_i,
   output logic shared_event_pin,
   output logic ext_event_pin,
   output logic oscillator_pins
);
   logic [1:0] osc_q;
   // A toggle output owns the board pin only while its enable is up
   assign shared_count_pin_i = shared_count_pin_oe ? shared_count_pin_o
                                                    : lvl[0];
   assign count_input_pin_i = count_input_pin_oe ? count_input_pin_o : lvl[1];
   assign shared_event_pin = lvl[2];
   assign ext_event_pin = lvl[3];
   // Oscillator runs at a quarter of the bus clock, slower as it must be
   assign oscillator_pins = osc_q[1];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         osc_q <= 2'h0;
      else
         osc_q <= osc_q + 2'h1;
   end
endmodule

/* test/tb_updown_timer_capture_reload.sv */
module tb_updown_timer_capture_reload;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] CTL = tmr_pkg::IDX_TIMER_CONTROL_REG;
   localparam logic [7:0] CFG = tmr_pkg::IDX_TIMER_CONFIG_REG;
   localparam logic [7:0] RLD = tmr_pkg::IDX_RELOAD_CAPTURE_LOW;
   localparam logic [7:0] CNT = tmr_pkg::IDX_COUNT_LOW_REG;
   typedef struct packed {
      logic [1:0] t;
      logic [7:0] idx;
      logic [7:0] wd;
      logic [7:0] exp;
   } row_t;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready, pslverr, e;
   logic [3:0] lvl = 4'hF;
   logic sc_i, sc_o, sc_oe, ci_i, ci_o, ci_oe, sh_ev, ev4, osc;
   logic [2:0] irq_req;
   logic [1:0] adc_start;
   logic [2:0] dac_update;
   logic [7:0] d;
   int fails = 0;
   int checks = 0;
   int n;
   int adc_n [2] = '{0, 0};
   int dac_n [3] = '{0, 0, 0};
   row_t rows [8] = '{'{2'h0, 8'hCA, 8'h5A, 8'h5A}, '{2'h1, 8'hCB, 8'hA5, 8'hA5},
      '{2'h2, 8'hCC, 8'h3C, 8'h3C}, '{2'h2, 8'hCD, 8'hC3, 8'hC3},
      '{2'h0, 8'hC9, 8'hFF, 8'h1F}, '{2'h1, 8'hC9, 8'hFF, 8'h1B},
      '{2'h1, 8'hC8, 8'h3B, 8'h0B}, '{2'h2, 8'hC9, 8'hE0, 8'h00}};
   logic [1:0] sel [4] = '{2'h1, 2'h3, 2'h0, 2'h2};
   int per [4] = '{10, 20, 120, 320};

   updown_timer_capture_reload updown_timer_capture_reload_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .shared_count_pin_i(sc_i),
      .shared_count_pin_o(sc_o), .shared_count_pin_oe(sc_oe),
      .count_input_pin_i(ci_i), .count_input_pin_o(ci_o),
      .count_input_pin_oe(ci_oe), .shared_event_pin(sh_ev),
      .ext_event_pin(ev4), .oscillator_pins(osc), .irq_req(irq_req),
      .adc_start(adc_start), .dac_update(dac_update));
   pin_model pin_model_i (
      .pclk(pclk), .presetn(presetn), .lvl(lvl), .shared_count_pin_o(sc_o),
      .shared_count_pin_oe(sc_oe), .count_input_pin_o(ci_o),
      .count_input_pin_oe(ci_oe), .shared_count_pin_i(sc_i),
      .count_input_pin_i(ci_i), .shared_event_pin(sh_ev),
      .ext_event_pin(ev4), .oscillator_pins(osc));

   always #20 pclk = ~pclk;
   always @(posedge pclk) begin
      for (int i = 0; i < 3; i++) dac_n[i] += int'(dac_update[i]);
      for (int i = 0; i < 2; i++) adc_n[i] += int'(adc_start[i]);
   end

   task automatic report_and_stop;
      $display("Checks %0d, errors %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] r);
      checks++;
      if (r !== x) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, x, r);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] wd,
                      output logic [7:0] rd, output logic err);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
         fails++;
         report_and_stop();
      end
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [1:0] t, input logic [7:0] i, input logic [7:0] w);
      apb(1'b1, {t, i, 2'h0}, w, d, e);
   endtask
   task automatic rd8(input logic [1:0] t, input logic [7:0] i, output logic [7:0] r);
      apb(1'b0, {t, i, 2'h0}, 8'h00, r, e);
   endtask
   task automatic wr16(input logic [1:0] t, input logic [7:0] i, input logic [15:0] w);
      wr(t, i, w[7:0]);
      wr(t, i + 8'h01, w[15:8]);
   endtask
   task automatic chk8(input string nm, input logic [1:0] t, input logic [7:0] i,
                       input logic [7:0] x);
      logic [7:0] r;
      rd8(t, i, r);
      chk(nm, {8'h00, x}, {8'h00, r});
   endtask
   task automatic chk16(input string nm, input logic [1:0] t, input logic [7:0] i,
                        input logic [15:0] x);
      logic [7:0] lo, hi;
      rd8(t, i, lo);
      rd8(t, i + 8'h01, hi);
      chk(nm, x, {hi, lo});
   endtask
   // Pin change lands after the synchroniser and filter, hence the waits
   task automatic set_pin(input int i, input logic b);
      @(posedge pclk);
      lvl[i] <= b;
      repeat (8) @(posedge pclk);
   endtask
   task automatic pin_fall(input int i);
      set_pin(i, 1'b0);
      set_pin(i, 1'b1);
   endtask
   // First change may be a forced level or a partial period, so skip two
   task automatic span(output int c);
      logic last;
      repeat (3) begin
         c = 0;
         last = sc_o;
         while (sc_o === last && c < 1000) begin
            @(posedge pclk);
            c++;
         end
      end
      if (c >= 1000) begin
         fails++;
         report_and_stop();
      end
   endtask

   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      for (int t = 0; t < 3; t++)
         for (int k = 0; k < 6; k++)
            chk8("reset reg", 2'(t), CTL + 8'(k), 8'h00);
      chk("reset outs", 16'h0000, {11'h0, irq_req, sc_oe, ci_oe});
      foreach (rows[i]) chk8("row reset", rows[i].t, rows[i].idx, 8'h00);
      foreach (rows[i]) begin
         wr(rows[i].t, rows[i].idx, rows[i].wd);
         chk8("row", rows[i].t, rows[i].idx, rows[i].exp);
      end
      apb(1'b1, 12'hC20, 8'hFF, d, e);
      chk("unmapped err", 16'h0001, {15'h0, e});
      apb(1'b0, 12'h321, 8'h00, d, e);
      chk("misaligned", 16'h0100, {7'h0, e, d});
      wr(2'h0, CFG, 8'h00);
      wr(2'h1, CFG, 8'h00);
      wr16(2'h1, CNT, 16'h1234);
      wr(2'h1, CTL, 8'h0B);
      pin_fall(2);
      chk8("capture flag", 2'h1, CTL, 8'h4B);
      chk("capture irq", 16'h0001, {15'h0, irq_req[1]});
      chk16("capture", 2'h1, RLD, 16'h1234);
      chk16("no trigger", 2'h0, RLD, 16'h005A);
      wr(2'h1, CTL, 8'h07);
      wr16(2'h1, CNT, 16'hFFFF);
      pin_fall(0);
      chk16("overflow", 2'h1, CNT, 16'h0000);
      chk8("wrap flag", 2'h1, CTL, 8'h87);
      chk("adc", 16'h0001, 16'(adc_n[1]));
      chk("dac", 16'h0001, 16'(dac_n[1]));
      pin_fall(0);
      chk8("flag kept", 2'h1, CTL, 8'h87);
      wr(2'h1, CTL, 8'h00); // Software clears both flags
      wr(2'h2, CFG, 8'h01);
      wr16(2'h2, CNT, 16'h0000);
      wr(2'h2, CTL, 8'h0F);
      set_pin(3, 1'b0);
      pin_fall(1);
      chk16("down wrap", 2'h2, CNT, 16'hFFFF);
      chk8("down flags", 2'h2, CTL, 8'h8F);
      chk16("no dir capture", 2'h2, RLD, 16'h0000);
      set_pin(3, 1'b1);
      pin_fall(1);
      chk16("up again", 2'h2, CNT, 16'h0000);
      chk("dac4", 16'h0002, 16'(dac_n[2]));
      wr(2'h2, CFG, 8'h00);
      wr16(2'h2, RLD, 16'h1234);
      wr16(2'h2, CNT, 16'hFFFF);
      wr(2'h2, CTL, 8'h06);
      pin_fall(1);
      chk16("reload", 2'h2, CNT, 16'h1234);
      chk8("reload flags", 2'h2, CTL, 8'hC6);
      pin_fall(1);
      chk16("continue", 2'h2, CNT, 16'h1235);
      wr(2'h2, CFG, 8'h01);
      wr(2'h2, CTL, 8'h0E);
      set_pin(3, 1'b0);
      pin_fall(1);
      chk16("down step", 2'h2, CNT, 16'h1234);
      chk8("dir only", 2'h2, CTL, 8'h0E);
      pin_fall(1);
      chk16("underflow", 2'h2, CNT, 16'hFFFF);
      chk8("under flags", 2'h2, CTL, 8'hCE);
      wr(2'h2, CFG, 8'h00);
      set_pin(3, 1'b1);
      wr(2'h2, CTL, 8'h0E);
      wr16(2'h2, CNT, 16'h5555);
      pin_fall(3);
      chk16("pin reload", 2'h2, CNT, 16'h1234);
      chk8("pin flag", 2'h2, CTL, 8'h4E);
      chk("pin irq", 16'h0001, {15'h0, irq_req[2]});
      wr(2'h2, CTL, 8'h02);
      pin_fall(1);
      chk16("stopped", 2'h2, CNT, 16'h1234);
      wr16(2'h0, RLD, 16'hFFF6);
      for (int k = 0; k < 4; k++) begin
         wr(2'h0, CFG, {3'h0, sel[k], 3'h2});
         // Start near the top so the first wrap comes within the wait bound
         wr16(2'h0, CNT, 16'hFFF6);
         wr(2'h0, CTL, 8'h04);
         span(n);
         chk("half period", 16'(per[k]), 16'(n));
         chk("toggle oe", 16'h0001, {15'h0, sc_oe});
      end
      wr(2'h0, CTL, 8'h00);
      wr(2'h0, CFG, 8'h06);
      chk8("force high", 2'h0, CFG, 8'h06);
      chk("pin high", 16'h0001, {15'h0, sc_o});
      wr(2'h0, CFG, 8'h02);
      chk8("force low", 2'h0, CFG, 8'h02);
      chk("pin low", 16'h0000, {15'h0, sc_o});
      wr(2'h0, CTL, 8'h04);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      chk16("rereset", 2'h0, RLD, 16'h0000);
      chk8("rereset ctl", 2'h0, CTL, 8'h00);
      report_and_stop();
   end
endmodule
